// File: cold_load_defs.vh
`ifndef COLD_LOAD_DEFS_VH
`define COLD_LOAD_DEFS_VH
// cycle timing: 5 ms processing cycle at 100 MHz (10 ns)
`define CYCLE_TIME_NS 5000000
`define CLK_PERIOD_NS 10
`define CYCLE_CLKS (`CYCLE_TIME_NS / `CLK_PERIOD_NS)
// magnitudes and thresholds in units of 0.01 x nominal current
`define LOW_THR_RST 16'h0014
`define HIGH_THR_RST 16'h0078
`define OVER_THR_RST 16'h00C8
// reset ratio 97 percent
`define RESET_RATIO_NUM 8'h61
`define RESET_RATIO_DEN 8'h64
// timers in units of 5 ms cycles
`define START_DLY_RST 20'h007D0
`define MAX_DLY_RST 20'h01770
`define MIN_DLY_RST 20'h00008
// register byte offsets
`define REG_STATUS 12'h000
`define REG_STATE 12'h004
`define REG_IRQ_EN 12'h008
`define REG_IRQ_CLR 12'h00C
`define REG_CTRL 12'h010
`define REG_LOW_THR 12'h020
`define REG_HIGH_THR 12'h024
`define REG_OVER_THR 12'h028
`define REG_START_DLY 12'h030
`define REG_MAX_DLY 12'h034
`define REG_MIN_DLY 12'h038
// status code values
`define CODE_NORMAL 3'h0
`define CODE_LOW 3'h1
`define CODE_OVER 3'h2
`define CODE_PICKUP 3'h3
`define CODE_BLOCKED 3'h4
// event bit positions
`define EV_ACT_ON 0
`define EV_ACT_OFF 1
`define EV_BLK_ON 2
`define EV_BLK_OFF 3
`define EV_OVER_ON 4
`define EV_LOW_ON 5
`define EV_HIGH_ON 6
`define EV_COUNT 7
`endif

// File: cold_load_detector.v
`timescale 1ns/10ps
`include "cold_load_defs.vh"
// Function
// - three phase magnitudes taken, refreshed each 5 ms cycle
// - every phase compared against one shared threshold per kind
// - comparators release below 97 percent of threshold
// - low condition when all phases below low threshold, default 0.20
// - inrush condition when all phases above high threshold, default 1.20
// - any phase above overcurrent threshold drops active output at the second cycle tick (comparator tick, then state tick)
// - settings rewritable at any time while detection runs
// - blocking input sampled once at each cycle start
// - pick-up unblocked asserts active output then runs timers
// - pick-up while blocked asserts blocked output only
// - blocking after activation clears active output as release
// - read-only status code with five states
// - start timer needs low condition for set time, default 10 s
// - maximum timer from inrush start releases output, default 30 s
// - minimum timer holds output at least 0.040 s against return-to-normal release only, reclaim window
module cold_load_detector
#(
    parameter MAG_W = 16,
    parameter TMR_W = 20,
    parameter CYCLE_CLKS = `CYCLE_CLKS
)
(
    input wire mclk,
    input wire reset_n,
    input wire [MAG_W-1:0] phaseAMag,
    input wire [MAG_W-1:0] phaseBMag,
    input wire [MAG_W-1:0] phaseCMag,
    input wire blockIn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg pickupActive,
    output reg pickupBlocked,
    output reg [2:0] statusCode,
    output wire irq
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_ARMED = 4'b0010;
    localparam ST_ACTIVE = 4'b0100;
    localparam ST_BLOCKED = 4'b1000;

    reg [3:0] state_q;
    reg [31:0] div_q;
    reg tick_q;
    reg blkSample_q;
    reg inrushSeen_q;
    reg measured_q;
    reg [MAG_W-1:0] lowThr_q;
    reg [MAG_W-1:0] highThr_q;
    reg [MAG_W-1:0] overThr_q;
    reg [TMR_W-1:0] startDly_q;
    reg [TMR_W-1:0] maxDly_q;
    reg [TMR_W-1:0] minDly_q;
    reg enable_q;
    reg [`EV_COUNT-1:0] evStat_q;
    reg [`EV_COUNT-1:0] evEn_q;
    reg [`EV_COUNT-1:0] ev;
    reg [3:0] state_d;
    wire [2:0] aboveLow;
    wire [2:0] aboveHigh;
    wire [2:0] aboveOver;
    wire lowCond;
    wire inrushCond;
    wire overCond;
    wire startExp;
    wire maxExp;
    wire minExp;
    wire wrEn;
    wire rdEn;
    wire inActive;

    // ------------------------------------------------------------------
    // processing cycle time base
    // ------------------------------------------------------------------
    // cycle tick
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= 32'h00000000;
            tick_q <= 1'b0;
        end
        else if (div_q >= CYCLE_CLKS - 1)
        begin
            div_q <= 32'h00000000;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            blkSample_q <= 1'b0;
        else if (tick_q)
            blkSample_q <= blockIn;
    end

    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------
    function [MAG_W-1:0] phaseMag;
        input integer idx;
        begin
            case (idx)
                0: phaseMag = phaseAMag;
                1: phaseMag = phaseBMag;
                default: phaseMag = phaseCMag;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : ph
            hyst_compare #(.WIDTH(MAG_W)) cmpLow (
                .mclk(mclk), .reset_n(reset_n), .update(tick_q),
                .magnitude(phaseMag(g)), .threshold(lowThr_q),
                .over(aboveLow[g]));
            hyst_compare #(.WIDTH(MAG_W)) cmpHigh (
                .mclk(mclk), .reset_n(reset_n), .update(tick_q),
                .magnitude(phaseMag(g)), .threshold(highThr_q),
                .over(aboveHigh[g]));
            hyst_compare #(.WIDTH(MAG_W)) cmpOver (
                .mclk(mclk), .reset_n(reset_n), .update(tick_q),
                .magnitude(phaseMag(g)), .threshold(overThr_q),
                .over(aboveOver[g]));
        end
    endgenerate

    assign lowCond = measured_q && ~|aboveLow;
    assign inrushCond = &aboveHigh;
    assign overCond = |aboveOver;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    assign inActive = (state_q == ST_ACTIVE);

    cycle_timer #(.WIDTH(TMR_W)) startTmr (
        .mclk(mclk), .reset_n(reset_n), .tick(tick_q),
        .run(state_q == ST_ARMED), .delay(startDly_q),
        .expired(startExp));
    cycle_timer #(.WIDTH(TMR_W)) maxTmr (
        .mclk(mclk), .reset_n(reset_n), .tick(tick_q),
        .run(inActive && inrushSeen_q), .delay(maxDly_q),
        .expired(maxExp));
    cycle_timer #(.WIDTH(TMR_W)) minTmr (
        .mclk(mclk), .reset_n(reset_n), .tick(tick_q),
        .run(inActive), .delay(minDly_q),
        .expired(minExp));

    // ------------------------------------------------------------------
    // detector state machine
    // ------------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (enable_q && tick_q && lowCond)
                    state_d = ST_ARMED;
            ST_ARMED:
                if (!lowCond || !enable_q)
                    state_d = ST_IDLE;
                else if (startExp && tick_q)
                begin
                    if (blkSample_q)
                        state_d = ST_BLOCKED;
                    else
                        state_d = ST_ACTIVE;
                end
            ST_ACTIVE:
                if (tick_q && (overCond || blkSample_q || maxExp ||
                    !enable_q))
                    state_d = ST_IDLE;
                else if (tick_q && minExp && !inrushCond && !lowCond)
                    state_d = ST_IDLE;
            ST_BLOCKED:
                if (tick_q && (!blkSample_q || !lowCond))
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            inrushSeen_q <= 1'b0;
            measured_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            measured_q <= measured_q | tick_q;
            if (state_d != ST_ACTIVE)
                inrushSeen_q <= 1'b0;
            else if (tick_q && inrushCond)
                inrushSeen_q <= 1'b1;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pickupActive <= 1'b0;
            pickupBlocked <= 1'b0;
            statusCode <= `CODE_NORMAL;
        end
        else
        begin
            pickupActive <= (state_d == ST_ACTIVE);
            pickupBlocked <= (state_d == ST_BLOCKED);
            if (state_d == ST_ACTIVE)
                statusCode <= `CODE_PICKUP;
            else if (state_d == ST_BLOCKED)
                statusCode <= `CODE_BLOCKED;
            else if (overCond)
                statusCode <= `CODE_OVER;
            else if (lowCond)
                statusCode <= `CODE_LOW;
            else
                statusCode <= `CODE_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    always @*
    begin
        ev = {`EV_COUNT{1'b0}};
        ev[`EV_ACT_ON] = (state_d == ST_ACTIVE) && !inActive;
        ev[`EV_ACT_OFF] = inActive && (state_d != ST_ACTIVE);
        ev[`EV_BLK_ON] = (state_d == ST_BLOCKED) && (state_q != ST_BLOCKED);
        ev[`EV_BLK_OFF] = (state_q == ST_BLOCKED) && (state_d != ST_BLOCKED);
        ev[`EV_OVER_ON] = tick_q && overCond;
        ev[`EV_LOW_ON] = (state_d == ST_ARMED) && (state_q == ST_IDLE);
        ev[`EV_HIGH_ON] = inActive && tick_q && inrushCond && !inrushSeen_q;
    end

    assign irq = |(evStat_q & evEn_q);

    // ------------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lowThr_q <= `LOW_THR_RST;
            highThr_q <= `HIGH_THR_RST;
            overThr_q <= `OVER_THR_RST;
            startDly_q <= `START_DLY_RST;
            maxDly_q <= `MAX_DLY_RST;
            minDly_q <= `MIN_DLY_RST;
            enable_q <= 1'b1;
            evEn_q <= {`EV_COUNT{1'b0}};
            evStat_q <= {`EV_COUNT{1'b0}};
            prdata <= 32'h00000000;
        end
        else
        begin
            if (wrEn && paddr == `REG_IRQ_CLR)
                evStat_q <= (evStat_q & ~pwdata[`EV_COUNT-1:0]) | ev;
            else
                evStat_q <= evStat_q | ev;
            if (wrEn)
            begin
                case (paddr)
                    `REG_CTRL: enable_q <= pwdata[0];
                    `REG_IRQ_EN: evEn_q <= pwdata[`EV_COUNT-1:0];
                    `REG_LOW_THR: lowThr_q <= pwdata[MAG_W-1:0];
                    `REG_HIGH_THR: highThr_q <= pwdata[MAG_W-1:0];
                    `REG_OVER_THR: overThr_q <= pwdata[MAG_W-1:0];
                    `REG_START_DLY: startDly_q <= pwdata[TMR_W-1:0];
                    `REG_MAX_DLY: maxDly_q <= pwdata[TMR_W-1:0];
                    `REG_MIN_DLY: minDly_q <= pwdata[TMR_W-1:0];
                    default: ;
                endcase
            end
            if (rdEn)
            begin
                case (paddr)
                    `REG_STATUS: prdata <= {25'h0000000, evStat_q};
                    `REG_STATE: prdata <= {26'h0000000, pickupBlocked,
                        pickupActive, blkSample_q, statusCode};
                    `REG_IRQ_EN: prdata <= {25'h0000000, evEn_q};
                    `REG_CTRL: prdata <= {31'h00000000, enable_q};
                    `REG_LOW_THR: prdata <= {16'h0000, lowThr_q};
                    `REG_HIGH_THR: prdata <= {16'h0000, highThr_q};
                    `REG_OVER_THR: prdata <= {16'h0000, overThr_q};
                    `REG_START_DLY: prdata <= {12'h000, startDly_q};
                    `REG_MAX_DLY: prdata <= {12'h000, maxDly_q};
                    `REG_MIN_DLY: prdata <= {12'h000, minDly_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// File: cold_load_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// port checker for the cold load detector
// ----------------------------------------------------------------------
module cold_load_props
#(
    parameter CYCLE_CLKS = 20
)
(
    input wire mclk,
    input wire reset_n,
    input wire [15:0] phaseAMag,
    input wire [15:0] phaseBMag,
    input wire [15:0] phaseCMag,
    input wire blockIn,
    input wire pickupActive,
    input wire pickupBlocked,
    input wire [2:0] statusCode
);
    localparam int LIM = 2 * CYCLE_CLKS + 3;
    logic [31:0] overCnt_q;
    logic [31:0] blkCnt_q;
    logic [31:0] blkAge_q;
    wire overNow = phaseAMag > 16'h00C8 || phaseBMag > 16'h00C8 ||
        phaseCMag > 16'h00C8;

    // run lengths of overcurrent and blocking, age of last block
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            overCnt_q <= 32'h0;
            blkCnt_q <= 32'h0;
            blkAge_q <= 32'h0;
        end
        else
        begin
            overCnt_q <= overNow ? overCnt_q + 32'h1 : 32'h0;
            blkCnt_q <= blockIn ? blkCnt_q + 32'h1 : 32'h0;
            blkAge_q <= blockIn ? 32'h0 : blkAge_q + 32'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_act_blk_excl:
    assert property (!(pickupActive && pickupBlocked))
        else $error("active and blocked together");
    a_code_active:
    assert property (pickupActive |-> statusCode == 3'h3)
        else $error("active without pick-up code");
    a_code_blocked:
    assert property (pickupBlocked |-> statusCode == 3'h4)
        else $error("blocked without blocked code");
    a_code_range:
    assert property (statusCode <= 3'h4)
        else $error("status code out of range");
    a_over_drop:
    assert property (overCnt_q >= LIM |-> !pickupActive)
        else $error("active kept during overcurrent");
    a_block_clears:
    assert property (blkCnt_q >= LIM |-> !pickupActive)
        else $error("active kept while blocked");
    a_blocked_cause:
    assert property ($rose(pickupBlocked) |-> blkAge_q <= LIM)
        else $error("blocked output without block");
    a_active_cause:
    assert property ($rose(pickupActive) |-> blkCnt_q <= LIM)
        else $error("active output while blocked");
endmodule

bind cold_load_detector cold_load_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props
(
    .mclk(mclk), .reset_n(reset_n), .phaseAMag(phaseAMag),
    .phaseBMag(phaseBMag), .phaseCMag(phaseCMag), .blockIn(blockIn),
    .pickupActive(pickupActive), .pickupBlocked(pickupBlocked),
    .statusCode(statusCode)
);

// File: cycle_timer.v
`timescale 1ns/10ps
`include "cold_load_defs.vh"
// ----------------------------------------------------------------------
// delay timer counting processing cycles
// ----------------------------------------------------------------------
module cycle_timer
#(
    parameter WIDTH = 20
)
(
    input wire mclk,
    input wire reset_n,
    input wire tick,
    input wire run,
    input wire [WIDTH-1:0] delay,
    output wire expired
);
    reg [WIDTH-1:0] count_q;
    assign expired = run && (count_q >= delay);
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= {WIDTH{1'b0}};
        else if (!run)
            count_q <= {WIDTH{1'b0}};
        else if (tick && count_q < delay)
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
endmodule

// File: feeder_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// phase current front end and blocking matrix
// ----------------------------------------------------------------------
module feeder_model
#(
    parameter CYCLE_CLKS = 20
)
(
    input wire mclk,
    input wire reset_n,
    input wire [15:0] setA,
    input wire [15:0] setB,
    input wire [15:0] setC,
    input wire setBlock,
    output reg [15:0] phaseAMag,
    output reg [15:0] phaseBMag,
    output reg [15:0] phaseCMag,
    output reg blockIn
);
    reg [31:0] cnt_q;

    // magnitudes refreshed once per time base
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 32'h0;
            phaseAMag <= 16'h0;
            phaseBMag <= 16'h0;
            phaseCMag <= 16'h0;
            blockIn <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == CYCLE_CLKS - 1) ? 32'h0 : cnt_q + 32'h1;
            if (cnt_q == 32'h0)
            begin
                phaseAMag <= setA;
                phaseBMag <= setB;
                phaseCMag <= setC;
            end
            // block passed on at once, well ahead of delays
            blockIn <= setBlock;
        end
    end
endmodule

// File: hyst_compare.v
`timescale 1ns/10ps
`include "cold_load_defs.vh"
// ----------------------------------------------------------------------
// threshold comparator with 97 percent release, per phase
// ----------------------------------------------------------------------
module hyst_compare
#(
    parameter WIDTH = 16
)
(
    input wire mclk,
    input wire reset_n,
    input wire update,
    input wire [WIDTH-1:0] magnitude,
    input wire [WIDTH-1:0] threshold,
    output reg over
);
    wire [WIDTH+7:0] magScaled;
    wire [WIDTH+7:0] relScaled;
    assign magScaled = {8'h00, magnitude} * `RESET_RATIO_DEN;
    assign relScaled = {8'h00, threshold} * `RESET_RATIO_NUM;
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            over <= 1'b0;
        else if (update)
        begin
            if (magnitude > threshold)
                over <= 1'b1;
            else if (magScaled < relScaled)
                over <= 1'b0;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
`include "cold_load_defs.vh"
// ----------------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------------
module tb_top;
    localparam int CYC = 20;
    logic mclk, reset_n, setBlock, blockIn;
    logic [15:0] setA, setB, setC, phaseAMag, phaseBMag, phaseCMag;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic pickupActive, pickupBlocked, irq;
    logic [2:0] statusCode;
    int errors = 0;
    int checked = 0;
    typedef struct {logic [11:0] a; logic [31:0] rst, wd, rb;} row_t;
    row_t rows[10] = '{
        '{`REG_STATUS, 32'h0, 32'hFF, 32'h0},
        '{`REG_STATE, 32'h0, 32'hFF, 32'h0},
        '{`REG_CTRL, 32'h1, 32'h1, 32'h1},
        '{`REG_LOW_THR, 32'h14, 32'h14, 32'h14},
        '{`REG_HIGH_THR, 32'h78, 32'h78, 32'h78},
        '{`REG_OVER_THR, 32'hC8, 32'hC8, 32'hC8},
        '{`REG_START_DLY, 32'h7D0, 32'h6, 32'h6},
        '{`REG_MAX_DLY, 32'h1770, 32'hA, 32'hA},
        '{`REG_MIN_DLY, 32'h8, 32'hA, 32'hA},
        '{12'hFFC, 32'h0, 32'hFFFF, 32'h0}};

    feeder_model #(.CYCLE_CLKS(CYC)) u_feed
    (
        .mclk(mclk), .reset_n(reset_n), .setA(setA), .setB(setB),
        .setC(setC), .setBlock(setBlock), .phaseAMag(phaseAMag),
        .phaseBMag(phaseBMag), .phaseCMag(phaseCMag), .blockIn(blockIn)
    );
    cold_load_detector #(.CYCLE_CLKS(CYC)) u_dut
    (
        .mclk(mclk), .reset_n(reset_n), .phaseAMag(phaseAMag),
        .phaseBMag(phaseBMag), .phaseCMag(phaseCMag), .blockIn(blockIn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pickupActive(pickupActive),
        .pickupBlocked(pickupBlocked), .statusCode(statusCode), .irq(irq)
    );

    task check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    begin
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task drive(input int a, input int b, input int c, input logic k);
    begin
        @(posedge mclk);
        setA <= a[15:0];
        setB <= b[15:0];
        setC <= c[15:0];
        setBlock <= k;
    end
    endtask

    task cyc(input int n);
    begin
        repeat (n) @(negedge mclk);
    end
    endtask

    task wait_out(input logic blk, input logic v, input int n);
        int k;
    begin
        k = 0;
        while (k < n && (blk ? pickupBlocked : pickupActive) !== v)
        begin
            @(negedge mclk);
            k++;
        end
    end
    endtask

    task activate;
    begin
        drive(10, 10, 10, 1'b0);
        wait_out(1'b0, 1'b1, 12 * CYC);
        check("active", pickupActive, 1'b1);
    end
    endtask

    task give_verdict;
    begin
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        repeat (30000) @(posedge mclk);
        errors++;
        give_verdict;
    end

    initial
    begin
        reset_n = 1'b0;
        {setA, setB, setC} = {3{16'h0032}};
        {setBlock, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0);
            check("reset value", d, rows[i].rst);
            apb(1'b1, rows[i].a, rows[i].wd);
            apb(1'b0, rows[i].a, 32'h0);
            check("readback", d, rows[i].rb);
            check("slave error", pslverr, 1'b0);
        end
        apb(1'b1, `REG_IRQ_EN, 32'h3);
        drive(10, 10, 10, 1'b0);
        cyc(4 * CYC);
        check("early start", pickupActive, 1'b0);
        check("low code", statusCode, `CODE_LOW);
        activate;
        drive(50, 50, 50, 1'b0);
        check("pickup code", statusCode, `CODE_PICKUP);
        check("irq raised", irq, 1'b1);
        apb(1'b1, `REG_IRQ_CLR, 32'h1);
        cyc(1);
        check("irq cleared", irq, 1'b0);
        apb(1'b1, `REG_IRQ_EN, 32'h1);
        cyc(5 * CYC);
        check("min hold", pickupActive, 1'b1);
        wait_out(1'b0, 1'b0, 10 * CYC);
        check("min release", pickupActive, 1'b0);
        check("irq masked", irq, 1'b0);
        apb(1'b1, `REG_IRQ_EN, 32'h2);
        cyc(1);
        check("irq unmasked", irq, 1'b1);
        apb(1'b1, `REG_IRQ_CLR, 32'h2);
        cyc(1);
        check("irq off", irq, 1'b0);
        apb(1'b1, `REG_MIN_DLY, 32'h2);
        activate;
        drive(130, 130, 130, 1'b0);
        cyc(2 * CYC);
        drive(118, 118, 118, 1'b0);
        cyc(5 * CYC);
        check("hysteresis hold", pickupActive, 1'b1);
        wait_out(1'b0, 1'b0, 8 * CYC);
        check("max release", pickupActive, 1'b0);
        drive(50, 50, 50, 1'b0);
        cyc(2 * CYC);
        activate;
        drive(250, 250, 250, 1'b0);
        cyc(3 * CYC + 3);
        check("over drop", pickupActive, 1'b0);
        check("over code", statusCode, `CODE_OVER);
        drive(50, 50, 50, 1'b0);
        cyc(2 * CYC);
        drive(10, 10, 10, 1'b1);
        wait_out(1'b1, 1'b1, 12 * CYC);
        check("blocked", pickupBlocked, 1'b1);
        check("no active", pickupActive, 1'b0);
        check("blocked code", statusCode, `CODE_BLOCKED);
        drive(10, 10, 10, 1'b0);
        wait_out(1'b1, 1'b0, 3 * CYC);
        check("unblocked", pickupBlocked, 1'b0);
        activate;
        drive(10, 10, 10, 1'b1);
        cyc(2 * CYC + 3);
        check("block release", pickupActive, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0);
        drive(10, 10, 10, 1'b0);
        cyc(12 * CYC);
        check("disabled", pickupActive, 1'b0);
        check("disabled code", statusCode, `CODE_LOW);
        give_verdict;
    end
endmodule
